//--- pkg/sbc_ctrl_map.vh
// register map, field positions, reset values and timing for the sbc control bank
`ifndef SBC_CTRL_MAP_VH
`define SBC_CTRL_MAP_VH

// register addresses (7-bit)
`define ADDR_MODE_SUPPLY_CONTROL  7'h01
`define ADDR_HARDWARE_CONTROL     7'h02
`define ADDR_WATCHDOG_CONTROL     7'h03

// frame layout, lsb received first
`define FRAME_BITS                5'h10
`define FRAME_ADDR_MSB            6
`define FRAME_ACCESS_BIT          7
`define FRAME_DATA_LSB            8
`define FRAME_DATA_MSB            15

// mode and supply control fields
`define MSC_MODE_MSB              7
`define MSC_MODE_LSB              6
`define MSC_RESERVED_BIT          5
`define MSC_SEC_SUPPLY_MSB        4
`define MSC_SEC_SUPPLY_LSB        3
`define MSC_OV_RESET_EN_BIT       2
`define MSC_RESET_THR_MSB         1
`define MSC_RESET_THR_LSB         0

// operating modes
`define MODE_NORMAL               2'h0
`define MODE_SLEEP                2'h1
`define MODE_STOP                 2'h2
`define MODE_SOFT_RESET           2'h3

// secondary supply modes
`define SEC_SUPPLY_OFF            2'h0
`define SEC_SUPPLY_NORMAL         2'h1
`define SEC_SUPPLY_NORMAL_STOP    2'h2
`define SEC_SUPPLY_ALWAYS         2'h3

// undervoltage threshold code that disables the reset
`define RESET_THR_DISABLED        2'h3

// hardware control fields
`define HWC_FAILSAFE_SEL_BIT      7
`define HWC_LAG_TIME_BIT          6
`define HWC_FAIL_FORCE_BIT        5
`define HWC_WAKE_PWM_BIT          4
`define HWC_AUTO_PWM_BIT          3
`define HWC_BOOST_VOLT_BIT        2
`define HWC_BOOST_EN_BIT          1
`define HWC_FAIL_CFG_BIT          0

// watchdog control checksum bit
`define WDC_CHECKSUM_BIT          7

// power-on / soft reset values
`define MSC_POR_VALUE             8'h00
`define HWC_POR_VALUE             8'h00
`define WDC_POR_VALUE             8'h14

// restart: kept bits and forced-one bits
`define MSC_RESTART_KEEP          8'h07
`define MSC_RESTART_SET           8'h00
`define HWC_RESTART_KEEP          8'hDF
`define HWC_RESTART_SET           8'h00
`define WDC_RESTART_KEEP          8'h98
`define WDC_RESTART_SET           8'h04

// timing
`define CLK_PERIOD_NS             20
`define LAG_SHORT_NS              100000
`define LAG_LONG_NS               1000000
`define RESET_PULSE_NS            10000
`define LAG_SHORT_CYC             (`LAG_SHORT_NS / `CLK_PERIOD_NS)
`define LAG_LONG_CYC              (`LAG_LONG_NS / `CLK_PERIOD_NS)
`define RESET_PULSE_CYC           (`RESET_PULSE_NS / `CLK_PERIOD_NS)

`endif

//--- hdl/pin_sync3.v
// three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
    parameter W = 1
) (
    // clock and reset
    input  wire         sys_clk_in,
    input  wire         rst_in,
    // pins and filtered levels
    input  wire [W-1:0] pin_in,
    input  wire [W-1:0] rst_level_in,
    output reg  [W-1:0] level_out
);

    reg [W-1:0] stage1_q;
    reg [W-1:0] stage2_q;
    reg [W-1:0] stage3_q;
    reg [W-1:0] level_d;
    integer     i;

    // a change counts only once stages two and three agree
    always @* begin
        level_d = level_out;
        for (i = 0; i < W; i = i + 1) begin
            if (stage2_q[i] == stage3_q[i]) begin
                level_d[i] = stage3_q[i];
            end
        end
    end

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1_q  <= {W{1'b0}};
            stage2_q  <= {W{1'b0}};
            stage3_q  <= {W{1'b0}};
            level_out <= {W{1'b0}};
        end else begin
            stage1_q  <= pin_in;
            stage2_q  <= stage1_q;
            stage3_q  <= stage2_q;
            level_out <= level_d;
        end
    end

    // async reset loads constants only, so the level input is unread
    wire unused_rst_level = |rst_level_in;

endmodule // pin_sync3

`default_nettype wire

//--- hdl/sbc_ctrl_regs.v
// spi-reached mode/supply, hardware and watchdog control registers of the sbc
//
// Functional notes
// R1: frame is 16 bits: 7-bit address, access bit, then data byte.
// R2: access bit 7 at zero reads one byte of the addressed register.
// R3: access bit 7 at one writes the data byte to the register.
// R4: register data bits D0..D7 sit at frame bits 8..15.
// R5: reset loads reset values; restart loads restart values, x bits keep contents.
// R6: read-only bits ignore writes; rw bits change only by host writes.
// R7: control bits are not cleared by the device; host rewrites them.
// R8: mode field 7:6 selects normal, sleep, stop; 11 soft-resets without reset pin.
// R9: bit 5 of mode and supply control is reserved, reads zero.
// R10: secondary supply field selects off, normal, normal+stop, normal+stop+sleep.
// R11: overvoltage reset enable makes primary overvoltage trigger a restart.
// R12: threshold field picks undervoltage threshold 1, 2, 3 or disables it.
// R13: sleep request without wake source enters restart and generates a reset.
// R14: failsafe select keeps monitor input at 0, makes pin a fail output at 1.
// R15: lag bit sets pwm to pfm delay: 100 us at 0, 1 ms at 1.
// R16: fail output force activates fail outputs; otherwise only a failure does.
// R17: in stop, wake pwm bit lets wake pin level choose pwm or pfm.
// R18: auto bit lets stop mode go pwm on large current; stop write returns.
// R19: boost voltage bit selects 8 V at 0, 6.65 V at 1.
// R20: boost enable allows boost to run whenever battery falls below threshold.
// R21: config bit: fail outputs after second watchdog failure at 0, first at 1.
// R22: configuration pin level decides fail-safe with primary supply off.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_ctrl_map.vh"

module sbc_ctrl_regs #(
    parameter LAG_SHORT_CYC   = `LAG_SHORT_CYC,
    parameter LAG_LONG_CYC    = `LAG_LONG_CYC,
    parameter RESET_PULSE_CYC = `RESET_PULSE_CYC
) (
    // clock and reset
    input  wire       sys_clk_in,
    input  wire       rst_in,
    // spi pins
    input  wire       spi_cs_n_in,
    input  wire       spi_sclk_in,
    input  wire       spi_mosi_in,
    output reg        spi_miso_out,
    output wire       spi_miso_oe_n_out,
    // analog and pin levels
    input  wire       primary_overvoltage_in,
    input  wire [2:0] primary_undervoltage_in,
    input  wire       battery_low_in,
    input  wire       wake_input_pin_in,
    input  wire       config_pin_in,
    // failsafe pin, two-way
    input  wire       failsafe_monitor_input_in,
    output wire       failsafe_pin_out,
    output wire       failsafe_pin_oe_n_out,
    // internal device logic
    input  wire       wake_sources_enabled_in,
    input  wire       watchdog_fail_in,
    input  wire       large_current_in,
    // control outputs
    output wire [1:0] sbc_mode_out,
    output reg        secondary_supply_on_out,
    output wire [1:0] primary_reset_threshold_out,
    output reg        reset_output_pin_n_out,
    output reg        buck_pwm_out,
    output wire       boost_on_out,
    output wire       boost_low_voltage_out,
    output wire       fail_outputs_out,
    output reg        failsafe_mode_out,
    output wire       failsafe_fail_out,
    output reg        spi_fail_out
);

    localparam SYNC_W = 10;

    // synchronised pin levels
    wire [SYNC_W-1:0] sync_level;
    wire cs_n_s    = sync_level[0];
    wire sclk_s    = sync_level[1];
    wire mosi_s    = sync_level[2];
    wire ov_s      = sync_level[3];
    wire [2:0] uv_s = sync_level[6:4];
    wire bat_low_s = sync_level[7];
    wire wake_s    = sync_level[8];
    wire cfg_s     = sync_level[9];

    wire fsi_s;

    pin_sync3 #(
        .W (SYNC_W)
    ) u_pin_sync (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .pin_in       ({config_pin_in, wake_input_pin_in, battery_low_in,
                        primary_undervoltage_in, primary_overvoltage_in,
                        spi_mosi_in, spi_sclk_in, spi_cs_n_in}),
        .rst_level_in ({SYNC_W{1'b0}}),
        .level_out    (sync_level)
    );

    pin_sync3 #(
        .W (1)
    ) u_fsi_sync (
        .sys_clk_in   (sys_clk_in),
        .rst_in       (rst_in),
        .pin_in       (failsafe_monitor_input_in),
        .rst_level_in (1'b0),
        .level_out    (fsi_s)
    );

    // registers
    reg [7:0]  mode_supply_control_q;
    reg [7:0]  hardware_control_q;
    reg [7:0]  watchdog_control_q;

    // spi frame state
    reg        cs_n_prev_q;
    reg        sclk_prev_q;
    reg [4:0]  bit_cnt_q;
    reg [15:0] rx_q;
    reg [7:0]  rd_byte_q;

    // restart, failure and buck state
    reg [15:0] reset_cnt_q;
    reg [1:0]  wd_fail_cnt_q;
    reg        auto_pwm_q;
    reg [15:0] lag_cnt_q;

    wire frame_start = cs_n_prev_q & ~cs_n_s;
    wire frame_end   = ~cs_n_prev_q & cs_n_s;
    wire sclk_rise   = ~cs_n_s & ~sclk_prev_q & sclk_s;
    wire sclk_fall   = ~cs_n_s & sclk_prev_q & ~sclk_s;

    // frames shorter than 16 bits are dropped whole; longer ones keep their first 16 bits
    wire frame_ok    = frame_end & (bit_cnt_q == `FRAME_BITS); // R1
    wire [6:0] f_addr = rx_q[`FRAME_ADDR_MSB:0]; // R1
    wire [7:0] f_data = rx_q[`FRAME_DATA_MSB:`FRAME_DATA_LSB]; // R4
    wire f_write     = frame_ok & rx_q[`FRAME_ACCESS_BIT]; // R3

    wire wr_msc = f_write & (f_addr == `ADDR_MODE_SUPPLY_CONTROL);
    wire wr_hwc = f_write & (f_addr == `ADDR_HARDWARE_CONTROL);
    wire wr_wdc = f_write & (f_addr == `ADDR_WATCHDOG_CONTROL);
    wire wdc_parity_ok = ~(^f_data);
    wire [1:0] wr_mode = f_data[`MSC_MODE_MSB:`MSC_MODE_LSB];

    wire soft_reset  = wr_msc & (wr_mode == `MODE_SOFT_RESET); // R8
    wire sleep_fault = wr_msc & (wr_mode == `MODE_SLEEP) & ~wake_sources_enabled_in; // R13
    wire stop_write  = wr_msc & (wr_mode == `MODE_STOP); // R18

    wire [1:0] cur_mode   = mode_supply_control_q[`MSC_MODE_MSB:`MSC_MODE_LSB];
    wire [1:0] sec_mode   = mode_supply_control_q[`MSC_SEC_SUPPLY_MSB:`MSC_SEC_SUPPLY_LSB];
    wire [1:0] thr_sel    = mode_supply_control_q[`MSC_RESET_THR_MSB:`MSC_RESET_THR_LSB];
    wire       ov_rst_en  = mode_supply_control_q[`MSC_OV_RESET_EN_BIT];

    // undervoltage below the selected threshold, code 11 disables
    reg uv_hit;
    always @* begin
        case (thr_sel)
            2'h0:    uv_hit = uv_s[0]; // R12
            2'h1:    uv_hit = uv_s[1]; // R12
            2'h2:    uv_hit = uv_s[2]; // R12
            default: uv_hit = 1'b0; // R12
        endcase
    end

    wire ov_hit = ov_rst_en & ov_s; // R11
    wire restart_trig = ov_hit | uv_hit | sleep_fault;

    // read mux: reserved bit 5 and checksum bit read as zero
    reg [7:0] rd_mux;
    always @* begin
        case (rx_q[`FRAME_ADDR_MSB:0])
            `ADDR_MODE_SUPPLY_CONTROL:
                rd_mux = mode_supply_control_q & ~(8'h01 << `MSC_RESERVED_BIT); // R9
            `ADDR_HARDWARE_CONTROL:
                rd_mux = hardware_control_q;
            `ADDR_WATCHDOG_CONTROL:
                rd_mux = watchdog_control_q & ~(8'h01 << `WDC_CHECKSUM_BIT);
            default:
                rd_mux = 8'h00;
        endcase
    end

    // spi shift engine, lsb of the frame first
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_n_prev_q  <= 1'b1;
            sclk_prev_q  <= 1'b0;
            bit_cnt_q    <= 5'h00;
            rx_q         <= 16'h0000;
            rd_byte_q    <= 8'h00;
            spi_miso_out <= 1'b0;
        end else begin
            cs_n_prev_q <= cs_n_s;
            sclk_prev_q <= sclk_s;
            if (frame_start) begin
                bit_cnt_q    <= 5'h00;
                spi_miso_out <= 1'b0;
            end else if (sclk_rise) begin
                if (bit_cnt_q < `FRAME_BITS) begin
                    rx_q[bit_cnt_q[3:0]] <= mosi_s;
                    bit_cnt_q            <= bit_cnt_q + 5'h01;
                end
                // address complete once bit 6 is in, latch the answer byte
                if (bit_cnt_q == 5'h07) begin
                    rd_byte_q <= rd_mux; // R2
                end
            end else if (sclk_fall) begin
                if (bit_cnt_q >= 5'h08 && bit_cnt_q < `FRAME_BITS) begin
                    spi_miso_out <= rd_byte_q[bit_cnt_q[2:0]]; // R4
                end else begin
                    spi_miso_out <= 1'b0;
                end
            end
        end
    end

    assign spi_miso_oe_n_out = cs_n_s;

    // register file: por, soft reset, restart and host writes
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_supply_control_q <= `MSC_POR_VALUE; // R5
            hardware_control_q    <= `HWC_POR_VALUE; // R5
            watchdog_control_q    <= `WDC_POR_VALUE; // R5
            spi_fail_out          <= 1'b0;
        end else begin
            spi_fail_out <= wr_wdc & ~wdc_parity_ok;
            if (soft_reset) begin
                // soft reset leaves the reset pin alone
                mode_supply_control_q <= `MSC_POR_VALUE; // R8
                hardware_control_q    <= `HWC_POR_VALUE; // R5
                watchdog_control_q    <= `WDC_POR_VALUE; // R5
            end else if (restart_trig) begin
                mode_supply_control_q <= (mode_supply_control_q & `MSC_RESTART_KEEP)
                                         | `MSC_RESTART_SET; // R5
                hardware_control_q    <= (hardware_control_q & `HWC_RESTART_KEEP)
                                         | `HWC_RESTART_SET; // R5
                watchdog_control_q    <= (watchdog_control_q & `WDC_RESTART_KEEP)
                                         | `WDC_RESTART_SET; // R5
            end else begin
                // only host writes change these bits
                if (wr_msc) begin
                    mode_supply_control_q <= f_data & ~(8'h01 << `MSC_RESERVED_BIT); // R6 R7
                end
                if (wr_hwc) begin
                    hardware_control_q <= f_data; // R6
                end
                if (wr_wdc && wdc_parity_ok) begin
                    watchdog_control_q <= f_data & ~(8'h01 << `WDC_CHECKSUM_BIT); // R6
                end
            end
        end
    end

    // restart reset pulse on the reset output pin
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_cnt_q            <= 16'h0000;
            reset_output_pin_n_out <= 1'b0;
        end else begin
            if (restart_trig) begin
                reset_cnt_q            <= RESET_PULSE_CYC[15:0]; // R11
                reset_output_pin_n_out <= 1'b0; // R13
            end else if (reset_cnt_q != 16'h0000) begin
                reset_cnt_q            <= reset_cnt_q - 16'h0001;
                reset_output_pin_n_out <= 1'b0;
            end else begin
                reset_output_pin_n_out <= 1'b1;
            end
        end
    end

    assign sbc_mode_out                = cur_mode;
    assign primary_reset_threshold_out = thr_sel; // R12

    // secondary supply per mode
    always @* begin
        case (sec_mode)
            `SEC_SUPPLY_NORMAL:
                secondary_supply_on_out = (cur_mode == `MODE_NORMAL); // R10
            `SEC_SUPPLY_NORMAL_STOP:
                secondary_supply_on_out = (cur_mode == `MODE_NORMAL) |
                                          (cur_mode == `MODE_STOP); // R10
            `SEC_SUPPLY_ALWAYS:
                secondary_supply_on_out = 1'b1; // R10
            default:
                secondary_supply_on_out = 1'b0; // R10
        endcase
    end

    // watchdog failures, fail outputs and failsafe pin
    wire fail_cfg_first = hardware_control_q[`HWC_FAIL_CFG_BIT];
    wire fsi_select_out = hardware_control_q[`HWC_FAILSAFE_SEL_BIT];
    wire wd_failed = fail_cfg_first ? (wd_fail_cnt_q != 2'h0)
                                    : (wd_fail_cnt_q == 2'h2); // R21

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wd_fail_cnt_q     <= 2'h0;
            failsafe_mode_out <= 1'b0;
        end else begin
            if (soft_reset) begin
                wd_fail_cnt_q <= {1'b0, watchdog_fail_in};
            end else if (watchdog_fail_in && wd_fail_cnt_q != 2'h2) begin
                wd_fail_cnt_q <= wd_fail_cnt_q + 2'h1;
            end
            // config pin low: a failure enters fail-safe, and beats a soft reset
            if (watchdog_fail_in && !cfg_s) begin
                failsafe_mode_out <= 1'b1; // R22
            end else if (soft_reset) begin
                failsafe_mode_out <= 1'b0;
            end
        end
    end

    // monitor input low while selected as input counts as a failure
    assign failsafe_fail_out = ~fsi_select_out & ~fsi_s; // R14
    assign fail_outputs_out  = hardware_control_q[`HWC_FAIL_FORCE_BIT] |
                               wd_failed | failsafe_fail_out; // R16
    assign failsafe_pin_out      = fail_outputs_out;
    assign failsafe_pin_oe_n_out = ~fsi_select_out; // R14

    // boost
    assign boost_on_out = hardware_control_q[`HWC_BOOST_EN_BIT] & bat_low_s; // R20
    assign boost_low_voltage_out = hardware_control_q[`HWC_BOOST_VOLT_BIT]; // R19

    // buck pwm request per mode
    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            auto_pwm_q <= 1'b0;
        end else if (stop_write || cur_mode != `MODE_STOP) begin
            auto_pwm_q <= 1'b0; // R18
        end else if (hardware_control_q[`HWC_AUTO_PWM_BIT] && large_current_in) begin
            auto_pwm_q <= 1'b1; // R18
        end
    end

    reg pwm_req;
    always @* begin
        case (cur_mode)
            `MODE_NORMAL:
                pwm_req = 1'b1;
            `MODE_STOP:
                pwm_req = (hardware_control_q[`HWC_WAKE_PWM_BIT] & wake_s) |
                          auto_pwm_q; // R17
            default:
                pwm_req = 1'b0;
        endcase
    end

    // pwm to pfm only after the lag time; pfm to pwm is immediate
    wire [15:0] lag_limit = hardware_control_q[`HWC_LAG_TIME_BIT] ?
                            LAG_LONG_CYC[15:0] : LAG_SHORT_CYC[15:0]; // R15

    always @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            buck_pwm_out <= 1'b1;
            lag_cnt_q    <= 16'h0000;
        end else if (pwm_req) begin
            buck_pwm_out <= 1'b1;
            lag_cnt_q    <= 16'h0000;
        end else if (buck_pwm_out) begin
            if (lag_cnt_q >= lag_limit - 16'h0001) begin
                buck_pwm_out <= 1'b0; // R15
                lag_cnt_q    <= 16'h0000;
            end else begin
                lag_cnt_q <= lag_cnt_q + 16'h0001;
            end
        end
    end

endmodule // sbc_ctrl_regs

`default_nettype wire

//--- bench/sbc_ctrl_regs_chk.sv
// concurrent port checks for the sbc control register bank
`timescale 1ns/1ps
`default_nettype none

module sbc_ctrl_regs_chk (
    // clock and reset
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    // watched ports
    input wire logic       spi_cs_n_in,
    input wire logic       spi_miso_oe_n_out,
    input wire logic       battery_low_in,
    input wire logic       boost_on_out,
    input wire logic       failsafe_pin_out,
    input wire logic       failsafe_pin_oe_n_out,
    input wire logic       fail_outputs_out,
    input wire logic       failsafe_fail_out,
    input wire logic       reset_output_pin_n_out,
    input wire logic [1:0] sbc_mode_out
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    // pulse is longer; eight keeps the unroll small
    sequence s_pin_low;
        !reset_output_pin_n_out [*8];
    endsequence
    sequence s_cs_idle;
        spi_cs_n_in [*8];
    endsequence
    a_miso_released: assert property (s_cs_idle |-> spi_miso_oe_n_out)
        else $error("miso driven while deselected");
    a_miso_driven: assert property (!spi_cs_n_in [*8] |-> !spi_miso_oe_n_out)
        else $error("miso not driven in frame");
    a_boost_idle: assert property (!battery_low_in [*6] |-> !boost_on_out)
        else $error("boost runs without low battery");
    a_fail_pin_level: assert property (!failsafe_pin_oe_n_out |-> failsafe_pin_out == fail_outputs_out)
        else $error("second fail output level wrong");
    a_monitor_off: assert property (!failsafe_pin_oe_n_out |-> !failsafe_fail_out)
        else $error("monitor active while pin is output");
    a_monitor_fail: assert property (failsafe_fail_out |-> fail_outputs_out)
        else $error("monitor failure not on fail outputs");
    a_reset_pulse: assert property ($fell(reset_output_pin_n_out) |-> s_pin_low)
        else $error("reset pulse too short");
    a_soft_mode: assert property (sbc_mode_out != 2'h3)
        else $error("soft reset mode code stored");
endmodule // sbc_ctrl_regs_chk

`default_nettype wire

//--- bench/spi_host_model.sv
// spi master model standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
    // clock
    input  wire logic sys_clk_in,
    // device answer
    input  wire logic spi_miso_in,
    input  wire logic spi_miso_oe_n_in,
    // master drive
    output var  logic spi_cs_n_out,
    output var  logic spi_sclk_out,
    output var  logic spi_mosi_out
);
    logic miso_last;
    // released line shows no stale value
    wire  line = spi_miso_oe_n_in ? ~miso_last : spi_miso_in;
    initial begin
        {spi_cs_n_out, spi_sclk_out, spi_mosi_out, miso_last} = 4'h8;
    end
    always @(posedge sys_clk_in) begin
        if (!spi_miso_oe_n_in) miso_last <= spi_miso_in;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #2;
    endtask
    // phases of 8 clocks leave margin over the synchroniser
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
        int k;
        step(1);
        spi_cs_n_out = 1'b0;
        for (k = 0; k < 16; k++) begin
            spi_mosi_out = f[k];
            step(8);
            if (k >= 8) rd[k-8] = line;
            spi_sclk_out = 1'b1;
            step(8);
            spi_sclk_out = 1'b0;
        end
        step(8);
        spi_cs_n_out = 1'b1;
        spi_mosi_out = ~spi_mosi_out;
        step(10);
    endtask
endmodule // spi_host_model

`default_nettype wire

//--- bench/sbc_ctrl_regs_tb.sv
// self-checking bench for the sbc control register bank
`timescale 1ns/1ps
`default_nettype none

module sbc_ctrl_regs_tb;
    logic sys_clk_in, rst_in, primary_overvoltage_in, battery_low_in, wake_input_pin_in;
    logic config_pin_in, failsafe_monitor_input_in, wake_sources_enabled_in;
    logic watchdog_fail_in, large_current_in, low_seen, fail_seen;
    logic [2:0] primary_undervoltage_in;
    logic [7:0] rb;
    logic [31:0] r;
    logic [31:0] rows [0:13];
    wire spi_cs_n_in, spi_sclk_in, spi_mosi_in, spi_miso_out, spi_miso_oe_n_out;
    wire secondary_supply_on_out, reset_output_pin_n_out, buck_pwm_out, boost_on_out;
    wire boost_low_voltage_out, fail_outputs_out, failsafe_mode_out, failsafe_fail_out;
    wire failsafe_pin_out, failsafe_pin_oe_n_out, spi_fail_out;
    wire [1:0] sbc_mode_out, primary_reset_threshold_out;
    int n_errors = 0, n_checks = 0, i, n;

    sbc_ctrl_regs #(.LAG_SHORT_CYC(20), .LAG_LONG_CYC(60), .RESET_PULSE_CYC(10))
    sbc_ctrl_regs_inst (.*);
    spi_host_model spi_host_model_inst (.sys_clk_in, .spi_miso_in(spi_miso_out),
        .spi_miso_oe_n_in(spi_miso_oe_n_out), .spi_cs_n_out(spi_cs_n_in),
        .spi_sclk_out(spi_sclk_in), .spi_mosi_out(spi_mosi_in));

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        if (!rst_in && !reset_output_pin_n_out) low_seen <= 1'b1;
        if (spi_fail_out) fail_seen <= 1'b1;
    end
    task step(input int k);
        repeat (k) @(posedge sys_clk_in);
        #2;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [6:0] a, input logic [7:0] d);
        spi_host_model_inst.xfer({d, 1'b1, a}, rb);
    endtask
    task rdc(input logic [6:0] a, input logic [7:0] e);
        spi_host_model_inst.xfer({8'h00, 1'b0, a}, rb);
        chk(rb, e);
    endtask
    task wd_pulse;
        watchdog_fail_in = 1'b1;
        step(1);
        watchdog_fail_in = 1'b0;
        step(5);
    endtask
    task wrap_up;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        n_errors++;
        wrap_up;
    end
    initial begin
        // address, written byte, read-back, secondary supply expected
        rows = '{32'h013F1F01, 32'h01080801, 32'h01020200, 32'h01101001, 32'h01888800,
                 32'h01909001, 32'h01505000, 32'h01585801, 32'h02A5A500, 32'h025A5A00,
                 32'h03961600, 32'h03141400, 32'h03971400, 32'h05FF0000};
        {rst_in, primary_overvoltage_in, battery_low_in, wake_input_pin_in} = 4'h8;
        {config_pin_in, failsafe_monitor_input_in, wake_sources_enabled_in} = 3'h7;
        {watchdog_fail_in, large_current_in, low_seen, fail_seen} = 4'h0;
        primary_undervoltage_in = 3'h0;
        step(3);
        rst_in = 1'b0;
        step(10);
        chk({reset_output_pin_n_out, buck_pwm_out}, 8'h03);
        rdc(7'h01, 8'h00);
        rdc(7'h02, 8'h00);
        rdc(7'h03, 8'h14);
        for (i = 0; i < 14; i++) begin
            r = rows[i];
            wr(r[30:24], r[23:16]);
            rdc(r[30:24], r[15:8]);
            if (r[31:24] == 8'h01) begin
                chk({sbc_mode_out, primary_reset_threshold_out}, {r[23:22], r[17:16]});
                chk(secondary_supply_on_out, r[7:0]);
            end
            if (r[31:24] == 8'h02) begin
                chk({fail_outputs_out, boost_low_voltage_out, failsafe_pin_oe_n_out},
                    {r[21], r[18], ~r[23]});
            end
        end
        chk(fail_seen, 8'h01);
        for (i = 0; i < 4; i++) begin
            wr(7'h01, {5'h00, i[0], i[1], 1'b1});
            wr(7'h02, 8'hFF);
            low_seen = 1'b0;
            {primary_overvoltage_in, primary_undervoltage_in} = 4'hA;
            step(5);
            {primary_overvoltage_in, primary_undervoltage_in} = 4'h0;
            step(30);
            chk(low_seen, {7'h00, i != 2});
        end
        rdc(7'h01, 8'h07);
        rdc(7'h02, 8'hDF);
        low_seen = 1'b0;
        wr(7'h01, 8'hC0);
        chk(low_seen, 8'h00);
        rdc(7'h02, 8'h00);
        wake_sources_enabled_in = 1'b0;
        wr(7'h01, 8'h40);
        step(10);
        chk(low_seen, 8'h01);
        rdc(7'h01, 8'h00);
        wake_sources_enabled_in = 1'b1;
        for (i = 0; i < 2; i++) begin
            wr(7'h02, {1'b0, i[0], 6'h10});
            wake_input_pin_in = 1'b1;
            wr(7'h01, 8'h80);
            chk(buck_pwm_out, 8'h01);
            wake_input_pin_in = 1'b0;
            for (n = 0; n < 200 && buck_pwm_out; n++) step(1);
            chk(n >= (i ? 60 : 20) && n <= (i ? 70 : 30), 8'h01);
            if (n == 200) wrap_up;
        end
        wr(7'h02, 8'h08);
        large_current_in = 1'b1;
        step(10);
        large_current_in = 1'b0;
        step(40);
        chk(buck_pwm_out, 8'h01);
        wr(7'h01, 8'h80);
        step(40);
        chk(buck_pwm_out, 8'h00);
        wr(7'h01, 8'h00);
        wr(7'h02, 8'h00);
        wd_pulse;
        chk({fail_outputs_out, failsafe_mode_out}, 8'h00);
        wd_pulse;
        chk(fail_outputs_out, 8'h01);
        wr(7'h01, 8'hC0);
        wr(7'h02, 8'h03);
        wd_pulse;
        chk(fail_outputs_out, 8'h01);
        battery_low_in = 1'b1;
        failsafe_monitor_input_in = 1'b0;
        step(10);
        chk({boost_on_out, failsafe_fail_out}, 8'h03);
        config_pin_in = 1'b0;
        wr(7'h02, 8'h80);
        chk({boost_on_out, failsafe_fail_out}, 8'h00);
        wd_pulse;
        chk(failsafe_mode_out, 8'h01);
        wrap_up;
    end
endmodule // sbc_ctrl_regs_tb

bind sbc_ctrl_regs sbc_ctrl_regs_chk sbc_ctrl_regs_chk_inst (.sys_clk_in, .rst_in, .spi_cs_n_in,
    .spi_miso_oe_n_out, .battery_low_in, .boost_on_out, .failsafe_pin_out,
    .failsafe_pin_oe_n_out, .fail_outputs_out, .failsafe_fail_out, .reset_output_pin_n_out,
    .sbc_mode_out);

`default_nettype wire
